// ===== nfc_irq_ctrl.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "nfc_irq_params.svh"

module nfc_irq_ctrl
   import nfc_irq_pkg::*;
#(
   parameter int AW = 8,
   parameter int MW = 8,
   parameter int SW = 8
) (
   input wire logic CORE_CLK_IN,
   input wire logic NRST_IN,
   input wire logic CE_IN,
   input wire logic [AW-1:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [AW-1:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   input wire logic OSC_EN_IN,
   input wire logic OSC_STABLE_IN,
   input wire logic [9:0] FIFO_COUNT_IN,
   input wire logic RX_ACTIVE_IN,
   input wire logic TX_ACTIVE_IN,
   input wire logic RX_START_IN,
   input wire logic RX_END_IN,
   input wire logic TX_END_IN,
   input wire logic BIT_COLLISION_IN,
   input wire logic DISTURBANCE_SUPPRESSION_IN,
   input wire logic DIRECT_CMD_DONE_IN,
   input wire logic NO_RESP_TIMER_IN,
   input wire logic GP_TIMER_IN,
   input wire logic EXT_FIELD_IN,
   input wire logic CA_COLLISION_IN,
   input wire logic CA_GUARD_DONE_IN,
   input wire logic CA_NO_FIELD_IN,
   input wire logic CA_FIELD_ON_IN,
   input wire logic TARGET_MODE_IN,
   input wire logic BIT_RATE_FOUND_IN,
   input wire logic CRC_ERR_IN,
   input wire logic PARITY_ERR_IN,
   input wire logic SOFT_FRAME_ERR_IN,
   input wire logic HARD_FRAME_ERR_IN,
   input wire logic WAKE_TIMER_TIMEOUT_IN,
   input wire logic WAKE_TIMER_EVERY_IN,
   input wire logic WU_AM_DONE_IN,
   input wire logic [MW-1:0] WU_AM_DELTA_IN,
   input wire logic [MW-1:0] WU_AM_REF_IN,
   input wire logic WU_PM_DONE_IN,
   input wire logic [MW-1:0] WU_PM_DELTA_IN,
   input wire logic [MW-1:0] WU_PM_REF_IN,
   input wire logic WU_CM_DONE_IN,
   input wire logic [MW-1:0] WU_CM_DELTA_IN,
   input wire logic [MW-1:0] WU_CM_REF_IN,
   input wire logic FIELD_ON_WAIT_IN,
   input wire logic [SW-1:0] TIME_SLOT_NUMBER_FREE_IN,
   input wire logic ACTIVE_PEER_FIELD_ON_IN,
   input wire logic AUTO_RESP_RX_END_IN,
   input wire logic HIGH_RATE_ACTIVE_IN,
   input wire logic LOW_RATE_ACTIVE_STAR_IN,
   input wire logic LOW_RATE_ACTIVE_IN,
   output logic IRQ_OUT
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg8_t main_mask;
   reg8_t timer_mask;
   reg8_t error_wakeup_irq_mask;
   reg8_t passive_target_irq_mask;
   reg8_t main_irq_status;
   reg8_t timer_field_irq_status;
   reg8_t error_wakeup_irq_status;
   reg8_t passive_target_status;
   reg8_t main_set;
   reg8_t timer_set;
   reg8_t err_wu_set;
   reg8_t pt_set;
   reg8_t read_value;
   logic osc_meta;
   logic osc_sync;
   logic osc_ok_d;
   logic field_meta;
   logic field_sync;
   logic field_d;
   logic fifo_level_d;
   logic fifo_level_now;
   logic slot_level_d;
   logic slot_level_now;
   logic aw_held;
   logic w_held;
   logic [AW-1:0] aw_addr;
   reg8_t w_byte;
   logic w_lane;
   logic ar_take;
   reg_sel_t rd_sel;
   reg_sel_t wr_sel;

   function automatic reg_sel_t decode(input logic [AW-1:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         case (addr[AW-1:2])
            `NFC_IDX_MAIN_MASK: sel = SEL_MAIN_MASK;
            `NFC_IDX_TIMER_MASK: sel = SEL_TIMER_MASK;
            `NFC_IDX_ERR_WU_MASK: sel = SEL_ERR_WU_MASK;
            `NFC_IDX_PT_MASK: sel = SEL_PT_MASK;
            `NFC_IDX_MAIN_STAT: sel = SEL_MAIN_STAT;
            `NFC_IDX_TIMER_STAT: sel = SEL_TIMER_STAT;
            `NFC_IDX_ERR_WU_STAT: sel = SEL_ERR_WU_STAT;
            `NFC_IDX_PT_STAT: sel = SEL_PT_STAT;
            default: sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction : decode

   assign rd_sel = decode(S_AXI_ARADDR_IN);
   assign wr_sel = decode(aw_addr);
   assign ar_take = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Oscillator and field detector are analogue, so they are resynchronised
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         field_meta <= 1'b0;
         field_sync <= 1'b0;
      end else if (CE_IN) begin
         osc_meta <= OSC_STABLE_IN;
         osc_sync <= osc_meta;
         field_meta <= EXT_FIELD_IN;
         field_sync <= field_meta;
      end
   end

   // ----------------------------------------------------------------
   // Level conditions turned into single events
   // ----------------------------------------------------------------
   // Edges only, so a level that lingers is reported once per occurrence
   assign fifo_level_now = (RX_ACTIVE_IN & (FIFO_COUNT_IN > `NFC_FIFO_RX_LEVEL)) |
                           (TX_ACTIVE_IN & (FIFO_COUNT_IN < `NFC_FIFO_TX_LEVEL));
   assign slot_level_now = (TIME_SLOT_NUMBER_FREE_IN == SW'(`NFC_SLOTS_LEFT));

   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         osc_ok_d <= 1'b0;
         field_d <= 1'b0;
         fifo_level_d <= 1'b0;
         slot_level_d <= 1'b0;
      end else if (CE_IN) begin
         osc_ok_d <= OSC_EN_IN & osc_sync;
         field_d <= field_sync;
         fifo_level_d <= fifo_level_now;
         slot_level_d <= slot_level_now;
      end
   end

   // ----------------------------------------------------------------
   // Event vectors
   // ----------------------------------------------------------------
   always_comb begin
      main_set = `NFC_REG_RESET;
      main_set[`NFC_MAIN_OSC] = OSC_EN_IN & osc_sync & ~osc_ok_d;
      main_set[`NFC_MAIN_WL] = fifo_level_now & ~fifo_level_d;
      main_set[`NFC_MAIN_RXS] = RX_START_IN;
      main_set[`NFC_MAIN_RXE] = RX_END_IN;
      main_set[`NFC_MAIN_TXE] = TX_END_IN;
      main_set[`NFC_MAIN_COL] = BIT_COLLISION_IN;
      main_set[`NFC_MAIN_REST] = DISTURBANCE_SUPPRESSION_IN;
   end

   always_comb begin
      timer_set = `NFC_REG_RESET;
      timer_set[`NFC_TMR_DCT] = DIRECT_CMD_DONE_IN;
      timer_set[`NFC_TMR_NRE] = NO_RESP_TIMER_IN;
      timer_set[`NFC_TMR_GPE] = GP_TIMER_IN;
      timer_set[`NFC_TMR_EON] = field_sync & ~field_d;
      timer_set[`NFC_TMR_EOF] = ~field_sync & field_d;
      timer_set[`NFC_TMR_CAC] = CA_COLLISION_IN;
      timer_set[`NFC_TMR_CAT] = CA_GUARD_DONE_IN & CA_NO_FIELD_IN & CA_FIELD_ON_IN;
      timer_set[`NFC_TMR_NFCT] = TARGET_MODE_IN & BIT_RATE_FOUND_IN;
   end

   always_comb begin
      err_wu_set = `NFC_REG_RESET;
      err_wu_set[`NFC_EW_CRC] = CRC_ERR_IN;
      err_wu_set[`NFC_EW_PAR] = PARITY_ERR_IN;
      err_wu_set[`NFC_EW_SOFT] = SOFT_FRAME_ERR_IN;
      err_wu_set[`NFC_EW_HARD] = HARD_FRAME_ERR_IN;
      err_wu_set[`NFC_EW_WT] = WAKE_TIMER_TIMEOUT_IN & WAKE_TIMER_EVERY_IN;
      err_wu_set[`NFC_EW_AM] = WU_AM_DONE_IN & (WU_AM_DELTA_IN > WU_AM_REF_IN);
      err_wu_set[`NFC_EW_PM] = WU_PM_DONE_IN & (WU_PM_DELTA_IN > WU_PM_REF_IN);
      err_wu_set[`NFC_EW_CM] = WU_CM_DONE_IN & (WU_CM_DELTA_IN > WU_CM_REF_IN);
   end

   always_comb begin
      pt_set = `NFC_REG_RESET;
      pt_set[`NFC_PT_PPON] = FIELD_ON_WAIT_IN;
      pt_set[`NFC_PT_SLOT] = slot_level_now & ~slot_level_d;
      pt_set[`NFC_PT_APON] = ACTIVE_PEER_FIELD_ON_IN;
      pt_set[`NFC_PT_RXE] = AUTO_RESP_RX_END_IN;
      pt_set[`NFC_PT_HIGH] = HIGH_RATE_ACTIVE_IN;
      pt_set[`NFC_PT_STAR] = LOW_RATE_ACTIVE_STAR_IN;
      pt_set[`NFC_PT_LOW] = LOW_RATE_ACTIVE_IN;
   end

   // ----------------------------------------------------------------
   // Status registers, cleared by the read that returns them
   // ----------------------------------------------------------------
   nfc_irq_sticky #(.W(8), .KEEP(`NFC_MAIN_BITS)) main_flags (
      .clk_in(CORE_CLK_IN),
      .nrst_in(NRST_IN),
      .ce_in(CE_IN),
      .set_in(main_set),
      .clear_in(ar_take && rd_sel == SEL_MAIN_STAT),
      .flags_out(main_irq_status)
   );

   nfc_irq_sticky #(.W(8), .KEEP(`NFC_ALL_BITS)) timer_flags (
      .clk_in(CORE_CLK_IN),
      .nrst_in(NRST_IN),
      .ce_in(CE_IN),
      .set_in(timer_set),
      .clear_in(ar_take && rd_sel == SEL_TIMER_STAT),
      .flags_out(timer_field_irq_status)
   );

   // A read of its own address clears it, not a read of the main status
   nfc_irq_sticky #(.W(8), .KEEP(`NFC_ALL_BITS)) err_wu_flags (
      .clk_in(CORE_CLK_IN),
      .nrst_in(NRST_IN),
      .ce_in(CE_IN),
      .set_in(err_wu_set),
      .clear_in(ar_take && rd_sel == SEL_ERR_WU_STAT),
      .flags_out(error_wakeup_irq_status)
   );

   nfc_irq_sticky #(.W(8), .KEEP(`NFC_PT_BITS)) pt_flags (
      .clk_in(CORE_CLK_IN),
      .nrst_in(NRST_IN),
      .ce_in(CE_IN),
      .set_in(pt_set),
      .clear_in(ar_take && rd_sel == SEL_PT_STAT),
      .flags_out(passive_target_status)
   );

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   // Address and data are caught separately, the write happens once both are in
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_byte <= `NFC_REG_RESET;
         w_lane <= 1'b0;
         S_AXI_AWREADY_OUT <= 1'b0;
         S_AXI_WREADY_OUT <= 1'b0;
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT <= `NFC_RESP_OKAY;
      end else if (CE_IN) begin
         S_AXI_AWREADY_OUT <= ~aw_held & ~S_AXI_AWREADY_OUT & ~S_AXI_BVALID_OUT;
         S_AXI_WREADY_OUT <= ~w_held & ~S_AXI_WREADY_OUT & ~S_AXI_BVALID_OUT;
         if (S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR_IN;
            S_AXI_AWREADY_OUT <= 1'b0;
         end
         if (S_AXI_WVALID_IN & S_AXI_WREADY_OUT) begin
            w_held <= 1'b1;
            w_byte <= S_AXI_WDATA_IN[7:0];
            w_lane <= S_AXI_WSTRB_IN[0];
            S_AXI_WREADY_OUT <= 1'b0;
         end
         if (aw_held & w_held & ~S_AXI_BVALID_OUT) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= (wr_sel == SEL_NONE) ? `NFC_RESP_SLVERR : `NFC_RESP_OKAY;
         end else if (S_AXI_BVALID_OUT & S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Mask registers
   // ----------------------------------------------------------------
   // Writes to status addresses are accepted and ignored
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         main_mask <= `NFC_REG_RESET;
         timer_mask <= `NFC_REG_RESET;
         error_wakeup_irq_mask <= `NFC_REG_RESET;
         passive_target_irq_mask <= `NFC_REG_RESET;
      end else if (CE_IN && aw_held && w_held && !S_AXI_BVALID_OUT && w_lane) begin
         case (wr_sel)
            SEL_MAIN_MASK: main_mask <= w_byte & `NFC_MAIN_BITS;
            SEL_TIMER_MASK: timer_mask <= w_byte;
            SEL_ERR_WU_MASK: error_wakeup_irq_mask <= w_byte;
            SEL_PT_MASK: passive_target_irq_mask <= w_byte & `NFC_PT_BITS;
            default: main_mask <= main_mask;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always_comb begin
      case (rd_sel)
         SEL_MAIN_MASK: read_value = main_mask;
         SEL_TIMER_MASK: read_value = timer_mask;
         SEL_ERR_WU_MASK: read_value = error_wakeup_irq_mask;
         SEL_PT_MASK: read_value = passive_target_irq_mask;
         SEL_MAIN_STAT: read_value = main_irq_status;
         SEL_TIMER_STAT: read_value = timer_field_irq_status;
         SEL_ERR_WU_STAT: read_value = error_wakeup_irq_status;
         SEL_PT_STAT: read_value = passive_target_status;
         default: read_value = `NFC_REG_RESET;
      endcase
   end

   // Data is captured before the clear lands, so no flag is lost to the read
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         S_AXI_ARREADY_OUT <= 1'b0;
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT <= '0;
         S_AXI_RRESP_OUT <= `NFC_RESP_OKAY;
      end else if (CE_IN) begin
         if (ar_take) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT <= {24'h000000, read_value};
            S_AXI_RRESP_OUT <= (rd_sel == SEL_NONE) ? `NFC_RESP_SLVERR : `NFC_RESP_OKAY;
         end else if (S_AXI_RVALID_OUT & S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
         end else begin
            S_AXI_ARREADY_OUT <= ~S_AXI_RVALID_OUT;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt line
   // ----------------------------------------------------------------
   // Registered, so it follows the flags one cycle late
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         IRQ_OUT <= 1'b0;
      end else if (CE_IN) begin
         IRQ_OUT <= |(main_irq_status & ~main_mask) |
                    |(timer_field_irq_status & ~timer_mask) |
                    |(error_wakeup_irq_status & ~error_wakeup_irq_mask) |
                    |(passive_target_status & ~passive_target_irq_mask);
      end
   end

endmodule : nfc_irq_ctrl

// ===== nfc_irq_params.svh
`ifndef NFC_IRQ_PARAMS_SVH
`define NFC_IRQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define NFC_IDX_MAIN_MASK 6'h16
`define NFC_IDX_TIMER_MASK 6'h17
`define NFC_IDX_ERR_WU_MASK 6'h18
`define NFC_IDX_PT_MASK 6'h19
`define NFC_IDX_MAIN_STAT 6'h1A
`define NFC_IDX_TIMER_STAT 6'h1B
`define NFC_IDX_ERR_WU_STAT 6'h1C
`define NFC_IDX_PT_STAT 6'h1D

// ----------------------------------------------------------------
// Reset values and implemented bits
// ----------------------------------------------------------------
`define NFC_REG_RESET 8'h00
`define NFC_MAIN_BITS 8'hFE
`define NFC_PT_BITS 8'hFB
`define NFC_ALL_BITS 8'hFF

// ----------------------------------------------------------------
// Main status bit positions
// ----------------------------------------------------------------
`define NFC_MAIN_OSC 7
`define NFC_MAIN_WL 6
`define NFC_MAIN_RXS 5
`define NFC_MAIN_RXE 4
`define NFC_MAIN_TXE 3
`define NFC_MAIN_COL 2
`define NFC_MAIN_REST 1

// ----------------------------------------------------------------
// Timer and field status bit positions
// ----------------------------------------------------------------
`define NFC_TMR_DCT 7
`define NFC_TMR_NRE 6
`define NFC_TMR_GPE 5
`define NFC_TMR_EON 4
`define NFC_TMR_EOF 3
`define NFC_TMR_CAC 2
`define NFC_TMR_CAT 1
`define NFC_TMR_NFCT 0

// ----------------------------------------------------------------
// Error and wake-up status bit positions
// ----------------------------------------------------------------
`define NFC_EW_CRC 7
`define NFC_EW_PAR 6
`define NFC_EW_SOFT 5
`define NFC_EW_HARD 4
`define NFC_EW_WT 3
`define NFC_EW_AM 2
`define NFC_EW_PM 1
`define NFC_EW_CM 0

// ----------------------------------------------------------------
// Passive target status bit positions
// ----------------------------------------------------------------
`define NFC_PT_PPON 7
`define NFC_PT_SLOT 6
`define NFC_PT_APON 5
`define NFC_PT_RXE 4
`define NFC_PT_HIGH 3
`define NFC_PT_STAR 1
`define NFC_PT_LOW 0

// ----------------------------------------------------------------
// Thresholds and bus codes
// ----------------------------------------------------------------
`define NFC_FIFO_RX_LEVEL 10'h12C
`define NFC_FIFO_TX_LEVEL 10'h0C8
`define NFC_SLOTS_LEFT 4
`define NFC_RESP_OKAY 2'h0
`define NFC_RESP_SLVERR 2'h2

`endif

// ===== nfc_irq_pkg.sv
package nfc_irq_pkg;

   typedef logic [7:0] reg8_t;

   typedef enum logic [3:0] {
      SEL_MAIN_MASK = 4'b0000,
      SEL_TIMER_MASK = 4'b0001,
      SEL_ERR_WU_MASK = 4'b0010,
      SEL_PT_MASK = 4'b0011,
      SEL_MAIN_STAT = 4'b0100,
      SEL_TIMER_STAT = 4'b0101,
      SEL_ERR_WU_STAT = 4'b0110,
      SEL_PT_STAT = 4'b0111,
      SEL_NONE = 4'b1000
   } reg_sel_t;

endpackage : nfc_irq_pkg

// ===== nfc_irq_sticky.sv
`timescale 1ns/1ns

module nfc_irq_sticky #(
   parameter int W = 8,
   parameter logic [W-1:0] KEEP = '1
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic [W-1:0] set_in,
   input wire logic clear_in,
   output logic [W-1:0] flags_out
);

   // ----------------------------------------------------------------
   // Latched flags, a set in the clearing cycle survives
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         flags_out <= '0;
      end else if (ce_in) begin
         flags_out <= ((clear_in ? '0 : flags_out) | set_in) & KEEP;
      end
   end

endmodule : nfc_irq_sticky

// ===== nfc_irq_sva.sv
`timescale 1ns/1ns

module nfc_irq_chk (
   input wire logic CORE_CLK_IN,
   input wire logic NRST_IN,
   input wire logic CE_IN,
   input wire logic [7:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   input wire logic S_AXI_ARREADY_OUT,
   input wire logic [31:0] S_AXI_RDATA_OUT,
   input wire logic [1:0] S_AXI_RRESP_OUT,
   input wire logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   input wire logic S_AXI_AWVALID_IN,
   input wire logic S_AXI_AWREADY_OUT,
   input wire logic S_AXI_WREADY_OUT,
   input wire logic [1:0] S_AXI_BRESP_OUT,
   input wire logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN
);
   // ----------------------------------------------------------------
   // Read handshakes and unmapped reads
   // ----------------------------------------------------------------
   // Frozen clock enable stalls everything, so nothing is judged then
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (!NRST_IN || !CE_IN);

   sequence s_rd_take;
      S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   endsequence

   sequence s_rd_done;
      S_AXI_RVALID_OUT && S_AXI_RREADY_IN;
   endsequence

   a_rd_answer: assert property (s_rd_take |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
      else $error("read not answered one cycle after acceptance");
   a_rd_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
      S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT) && $stable(S_AXI_RRESP_OUT))
      else $error("read answer changed before it was taken");
   a_rd_release: assert property (s_rd_done |=> !S_AXI_RVALID_OUT ##[0:1] S_AXI_ARREADY_OUT)
      else $error("read channel not released after handshake");
   a_bad_addr: assert property (s_rd_take ##0 (S_AXI_ARADDR_IN < 8'h58 ||
      S_AXI_ARADDR_IN > 8'h74 || S_AXI_ARADDR_IN[1:0] != 2'b00) |=>
      S_AXI_RRESP_OUT == 2'h2 && S_AXI_RDATA_OUT == 32'h0)
      else $error("unmapped read not refused");

   // ----------------------------------------------------------------
   // Reserved bits and write channel
   // ----------------------------------------------------------------
   a_main_rsvd: assert property (s_rd_take ##0 S_AXI_ARADDR_IN == 8'h68 |=>
      S_AXI_RDATA_OUT[0] == 1'b0 && S_AXI_RDATA_OUT[31:8] == 24'h0)
      else $error("main status reserved bit not zero");
   a_pt_rsvd: assert property (s_rd_take ##0 S_AXI_ARADDR_IN == 8'h64 |=>
      S_AXI_RDATA_OUT[2] == 1'b0)
      else $error("passive target mask reserved bit not zero");
   a_wr_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
      S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
      else $error("write response dropped before taken");
   a_wr_refuse: assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
      else $error("new write offered while response pending");
   a_aw_pulse: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT |=> !S_AXI_AWREADY_OUT)
      else $error("write address ready held after acceptance");
endmodule : nfc_irq_chk

// ===== nfc_irq_mask_and_status_tb_top.sv
`timescale 1ns/1ns
`include "nfc_irq_params.svh"

module nfc_irq_mask_and_status_tb_top;
   // ----------------------------------------------------------------
   // Stimulus signals, events grouped into vectors for short pulses
   // ----------------------------------------------------------------
   logic CORE_CLK_IN = 1'b0, NRST_IN = 1'b0, CE_IN = 1'b1;
   logic [7:0] S_AXI_AWADDR_IN = 8'h00, S_AXI_ARADDR_IN = 8'h00;
   logic [31:0] S_AXI_WDATA_IN = 32'h0, S_AXI_RDATA_OUT, rd;
   logic [3:0] S_AXI_WSTRB_IN = 4'hF;
   logic S_AXI_AWVALID_IN = 1'b0, S_AXI_WVALID_IN = 1'b0, S_AXI_BREADY_IN = 1'b0;
   logic S_AXI_ARVALID_IN = 1'b0, S_AXI_RREADY_IN = 1'b0;
   logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
   logic S_AXI_RVALID_OUT, IRQ_OUT;
   logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, rr;
   logic OSC_EN_IN = 1'b0, OSC_STABLE_IN = 1'b0, RX_ACTIVE_IN = 1'b0, TX_ACTIVE_IN = 1'b0;
   logic EXT_FIELD_IN = 1'b0, CA_NO_FIELD_IN = 1'b0, CA_FIELD_ON_IN = 1'b0;
   logic TARGET_MODE_IN = 1'b0, WAKE_TIMER_EVERY_IN = 1'b0;
   logic [9:0] FIFO_COUNT_IN = 10'h000;
   logic [7:0] TIME_SLOT_NUMBER_FREE_IN = 8'h10, ep = 8'h00;
   logic [4:0] mp = 5'h00;
   logic [5:0] tp = 6'h00, pp = 6'h00;
   logic [47:0] wu = 48'h0;
   wire logic RX_START_IN, RX_END_IN, TX_END_IN, BIT_COLLISION_IN, DISTURBANCE_SUPPRESSION_IN;
   wire logic DIRECT_CMD_DONE_IN, NO_RESP_TIMER_IN, GP_TIMER_IN, CA_COLLISION_IN;
   wire logic CA_GUARD_DONE_IN, BIT_RATE_FOUND_IN, CRC_ERR_IN, PARITY_ERR_IN, SOFT_FRAME_ERR_IN;
   wire logic HARD_FRAME_ERR_IN, WAKE_TIMER_TIMEOUT_IN, WU_AM_DONE_IN, WU_PM_DONE_IN;
   wire logic WU_CM_DONE_IN, FIELD_ON_WAIT_IN, ACTIVE_PEER_FIELD_ON_IN, AUTO_RESP_RX_END_IN;
   wire logic HIGH_RATE_ACTIVE_IN, LOW_RATE_ACTIVE_STAR_IN, LOW_RATE_ACTIVE_IN;
   wire logic [7:0] WU_AM_DELTA_IN, WU_AM_REF_IN, WU_PM_DELTA_IN, WU_PM_REF_IN;
   wire logic [7:0] WU_CM_DELTA_IN, WU_CM_REF_IN;
   int errors = 0, num_checks = 0, cyc = 0;

   assign {RX_START_IN, RX_END_IN, TX_END_IN, BIT_COLLISION_IN, DISTURBANCE_SUPPRESSION_IN} = mp;
   assign {DIRECT_CMD_DONE_IN, NO_RESP_TIMER_IN, GP_TIMER_IN, CA_COLLISION_IN, CA_GUARD_DONE_IN,
      BIT_RATE_FOUND_IN} = tp;
   assign {CRC_ERR_IN, PARITY_ERR_IN, SOFT_FRAME_ERR_IN, HARD_FRAME_ERR_IN, WAKE_TIMER_TIMEOUT_IN,
      WU_AM_DONE_IN, WU_PM_DONE_IN, WU_CM_DONE_IN} = ep;
   assign {FIELD_ON_WAIT_IN, ACTIVE_PEER_FIELD_ON_IN, AUTO_RESP_RX_END_IN, HIGH_RATE_ACTIVE_IN,
      LOW_RATE_ACTIVE_STAR_IN, LOW_RATE_ACTIVE_IN} = pp;
   assign {WU_AM_DELTA_IN, WU_AM_REF_IN, WU_PM_DELTA_IN, WU_PM_REF_IN, WU_CM_DELTA_IN,
      WU_CM_REF_IN} = wu;

   nfc_irq_ctrl i_dut (.*);

   always #2 CORE_CLK_IN = ~CORE_CLK_IN;

   // Whole run needs well under a thousand cycles
   always @(posedge CORE_CLK_IN) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         end_of_test;
      end
   end

   // ----------------------------------------------------------------
   // Bus and checking tasks
   // ----------------------------------------------------------------
   task wt(input int n);
      repeat (n) @(posedge CORE_CLK_IN);
   endtask : wt

   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task axw(input logic [7:0] a, input logic [7:0] d);
      S_AXI_AWADDR_IN <= a;
      S_AXI_WDATA_IN <= {24'h0, d};
      S_AXI_AWVALID_IN <= 1'b1;
      S_AXI_WVALID_IN <= 1'b1;
      S_AXI_BREADY_IN <= 1'b1;
      do begin
         @(posedge CORE_CLK_IN);
         if (S_AXI_AWREADY_OUT === 1'b1) S_AXI_AWVALID_IN <= 1'b0;
         if (S_AXI_WREADY_OUT === 1'b1) S_AXI_WVALID_IN <= 1'b0;
      end while (S_AXI_BVALID_OUT !== 1'b1);
      rr = S_AXI_BRESP_OUT;
      S_AXI_BREADY_IN <= 1'b0;
      @(posedge CORE_CLK_IN);
   endtask : axw

   // Extra edge at the end keeps reads three cycles apart
   task axr(input logic [7:0] a);
      S_AXI_ARADDR_IN <= a;
      S_AXI_ARVALID_IN <= 1'b1;
      S_AXI_RREADY_IN <= 1'b1;
      do @(posedge CORE_CLK_IN); while (S_AXI_ARREADY_OUT !== 1'b1);
      S_AXI_ARVALID_IN <= 1'b0;
      do @(posedge CORE_CLK_IN); while (S_AXI_RVALID_OUT !== 1'b1);
      rd = S_AXI_RDATA_OUT;
      rr = S_AXI_RRESP_OUT;
      S_AXI_RREADY_IN <= 1'b0;
      @(posedge CORE_CLK_IN);
   endtask : axr

   task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      axr(a);
      check(n, rd, {24'h0, e});
   endtask : rchk

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_masks;
      rchk("ew mask rst", 8'h60, 8'h00);
      rchk("pt mask rst", 8'h64, 8'h00);
      axw(8'h60, 8'hA5);
      axw(8'h64, 8'hFF);
      check("wr resp", {30'h0, rr}, {30'h0, `NFC_RESP_OKAY});
      rchk("ew mask rw", 8'h60, 8'hA5);
      rchk("pt mask rw", 8'h64, 8'hFB);
      axr(8'h80);
      check("bad resp", {30'h0, rr}, {30'h0, `NFC_RESP_SLVERR});
      axw(8'h80, 8'h00);
      check("bad wr resp", {30'h0, rr}, {30'h0, `NFC_RESP_SLVERR});
      axw(8'h64, 8'h00);
      axw(8'h60, 8'h00);
   endtask : t_masks

   task t_main;
      mp <= 5'h1F;
      wt(1);
      mp <= 5'h00;
      wt(4);
      check("irq set", {31'h0, IRQ_OUT}, 32'h1);
      rchk("main flags", 8'h68, 8'h3E);
      rchk("main clear", 8'h68, 8'h00);
      check("irq clear", {31'h0, IRQ_OUT}, 32'h0);
   endtask : t_main

   task t_fifo;
      RX_ACTIVE_IN <= 1'b1;
      FIFO_COUNT_IN <= 10'd300;
      wt(3);
      rchk("rx 300", 8'h68, 8'h00);
      FIFO_COUNT_IN <= 10'd301;
      wt(3);
      RX_ACTIVE_IN <= 1'b0;
      TX_ACTIVE_IN <= 1'b1;
      FIFO_COUNT_IN <= 10'd200;
      rchk("rx 301", 8'h68, 8'h40);
      FIFO_COUNT_IN <= 10'd199;
      wt(3);
      TX_ACTIVE_IN <= 1'b0;
      OSC_EN_IN <= 1'b1;
      OSC_STABLE_IN <= 1'b1;
      wt(6);
      rchk("tx osc", 8'h68, 8'hC0);
   endtask : t_fifo

   task t_timer;
      tp <= 6'h02;
      wt(1);
      tp <= 6'h00;
      rchk("guard unqual", 8'h6C, 8'h00);
      CA_NO_FIELD_IN <= 1'b1;
      CA_FIELD_ON_IN <= 1'b1;
      TARGET_MODE_IN <= 1'b1;
      tp <= 6'h3F;
      wt(1);
      tp <= 6'h00;
      rchk("timer flags", 8'h6C, 8'hE7);
      rchk("timer clear", 8'h6C, 8'h00);
      EXT_FIELD_IN <= 1'b1;
      wt(5);
      rchk("field on", 8'h6C, 8'h10);
      EXT_FIELD_IN <= 1'b0;
      wt(5);
      rchk("field off", 8'h6C, 8'h08);
   endtask : t_timer

   task t_err;
      axw(8'h60, 8'hFF);
      wu <= 48'h05_04_04_04_09_02;
      WAKE_TIMER_EVERY_IN <= 1'b1;
      ep <= 8'hFF;
      wt(1);
      ep <= 8'h00;
      wt(3);
      check("irq masked", {31'h0, IRQ_OUT}, 32'h0);
      rchk("err flags", 8'h70, 8'hFD);
      rchk("err clear", 8'h70, 8'h00);
      WAKE_TIMER_EVERY_IN <= 1'b0;
      ep <= 8'h08;
      wt(1);
      ep <= 8'h00;
      rchk("wt no option", 8'h70, 8'h00);
      axw(8'h60, 8'h00);
   endtask : t_err

   task t_pt;
      TIME_SLOT_NUMBER_FREE_IN <= 8'h05;
      wt(2);
      rchk("slot five", 8'h74, 8'h00);
      TIME_SLOT_NUMBER_FREE_IN <= 8'h04;
      pp <= 6'h3F;
      wt(1);
      pp <= 6'h00;
      rchk("pt flags", 8'h74, 8'hFB);
      rchk("pt clear", 8'h74, 8'h00);
   endtask : t_pt

   task end_of_test;
      if (errors == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   initial begin
      wt(20);
      NRST_IN <= 1'b1;
      wt(1);
      t_masks;
      t_main;
      t_fifo;
      t_timer;
      t_err;
      t_pt;
      end_of_test;
   end
endmodule : nfc_irq_mask_and_status_tb_top

bind nfc_irq_ctrl nfc_irq_chk i_chk (.*);
